// ==== hdl/lpm_input_sense_config.sv ====
// Low power mode input sense configuration registers and comparator control
`timescale 1ns/10ps

// How it works
// R1: Comparator-only channel keeps comparator on in low power, polling current off.
// R2: Comparator-only inputs sampled at low-power clock; change wakes the device.
// R3: Host uses comparator-only only for chip-driven 5 V logic inputs.
// R4: Programmable comparator-only register at 0x12, bits 7-0, resets zero.
// R5: Ground comparator-only register at 0x13, bits 13-0, resets zero.
// R6: Ground-configured programmable channel, bit clear: use delta threshold.
// R7: Ground-configured programmable channel, bit set: use normal threshold.
// R8: Battery-configured programmable channel always uses the 4.0 V threshold.
// R9: Host sets enough current to cross 4.0 V when normal threshold chosen.
// R10: Programmable threshold register at 0x14, bits 7-0, resets zero.
// R11: Frame: address 31-25, write flag 24, data; reply fault, flag, data.
// R12: Unused bits ignore writes and read as zero.
module lpm_input_sense_config #(
   parameter int PROG_N = lpm_sense_pkg::PROG_CHANNELS,
   parameter int GND_N = lpm_sense_pkg::GND_CHANNELS
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Decoded frame from the serial shifter
   input wire logic frame_valid,
   input wire logic [31:0] frame_in,
   input wire logic fault_status,
   input wire logic interrupt_flag,
   output logic [23:0] reply_data,
   // Low power mode control
   input wire logic low_power_mode,
   input wire logic lp_tick,
   input wire logic [PROG_N-1:0] prog_to_battery,
   input wire logic [PROG_N-1:0] prog_comp_pin,
   input wire logic [GND_N-1:0] gnd_comp_pin,
   // Analog control
   output logic [PROG_N-1:0] prog_comp_enable,
   output logic [PROG_N-1:0] prog_poll_current,
   output logic [GND_N-1:0] gnd_comp_enable,
   output logic [GND_N-1:0] gnd_poll_current,
   output logic [2*PROG_N-1:0] prog_threshold,
   output logic wake_request
);
   logic [PROG_N-1:0] comparator_only_programmable;
   logic [GND_N-1:0] comparator_only_ground;
   logic [PROG_N-1:0] lowpower_threshold_programmable;
   logic [6:0] addr;
   logic wr;
   logic [23:0] wdata;
   logic [21:0] rd_field;
   logic [PROG_N-1:0] prog_s1;
   logic [PROG_N-1:0] prog_s2;
   logic [PROG_N-1:0] prog_last;
   logic [GND_N-1:0] gnd_s1;
   logic [GND_N-1:0] gnd_s2;
   logic [GND_N-1:0] gnd_last;
   logic [PROG_N-1:0] prog_change;
   logic [GND_N-1:0] gnd_change;
   logic write_en;
   logic any_change;

   assign addr = frame_in[lpm_sense_pkg::ADDR_MSB:lpm_sense_pkg::ADDR_LSB]; // R11
   assign wr = frame_in[lpm_sense_pkg::RW_BIT]; // R11
   assign wdata = frame_in[lpm_sense_pkg::DATA_BITS-1:0];
   assign write_en = frame_valid && wr; // R11

   // Register writes
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         comparator_only_programmable <= lpm_sense_pkg::RESET_COMP_ONLY_PROG; // R4
         comparator_only_ground <= lpm_sense_pkg::RESET_COMP_ONLY_GND; // R5
         lowpower_threshold_programmable <= lpm_sense_pkg::RESET_THRESH_PROG; // R10
      end
      else if (write_en)
      begin
         case (addr)
            lpm_sense_pkg::ADDR_COMP_ONLY_PROG:
               comparator_only_programmable <= wdata[PROG_N-1:0]; // R4 R12
            lpm_sense_pkg::ADDR_COMP_ONLY_GND:
               comparator_only_ground <= wdata[GND_N-1:0]; // R5 R12
            lpm_sense_pkg::ADDR_THRESH_PROG:
               lowpower_threshold_programmable <= wdata[PROG_N-1:0]; // R10 R12
            default:
               ;
         endcase
      end
   end

   // Read field selection
   always_comb
   begin
      rd_field = 22'h000000;
      case (addr)
         lpm_sense_pkg::ADDR_COMP_ONLY_PROG:
            rd_field[PROG_N-1:0] = comparator_only_programmable; // R12
         lpm_sense_pkg::ADDR_COMP_ONLY_GND:
            rd_field[GND_N-1:0] = comparator_only_ground; // R12
         lpm_sense_pkg::ADDR_THRESH_PROG:
            rd_field[PROG_N-1:0] = lowpower_threshold_programmable; // R12
         default:
            rd_field = 22'h000000;
      endcase
   end

   // Reply word, captured with the frame
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         reply_data <= 24'h000000;
      else if (frame_valid)
         reply_data <= {fault_status, interrupt_flag, rd_field}; // R11
   end

   // Comparator input synchronisers
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         prog_s1 <= '0;
         prog_s2 <= '0;
         gnd_s1 <= '0;
         gnd_s2 <= '0;
      end
      else
      begin
         prog_s1 <= prog_comp_pin;
         prog_s2 <= prog_s1;
         gnd_s1 <= gnd_comp_pin;
         gnd_s2 <= gnd_s1;
      end
   end

   // Sampling every clock when awake, at the low-power clock rate in low power mode
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         prog_last <= '0;
         gnd_last <= '0;
      end
      else if (!low_power_mode)
      begin
         prog_last <= prog_s2;
         gnd_last <= gnd_s2;
      end
      else if (lp_tick)
      begin
         prog_last <= prog_s2; // R2
         gnd_last <= gnd_s2; // R2
      end
   end

   // Change on a comparator-only input
   assign prog_change = (prog_s2 ^ prog_last) & comparator_only_programmable;
   assign gnd_change = (gnd_s2 ^ gnd_last) & comparator_only_ground;
   assign any_change = (|prog_change) || (|gnd_change); // R2

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         wake_request <= 1'b0;
      else
         wake_request <= low_power_mode && lp_tick && any_change; // R2
   end

   // Per-channel comparator, current and threshold control
   genvar i;
   generate
      for (i = 0; i < PROG_N; i++)
      begin : g_prog
         lpm_sense_pkg::threshold_type next_threshold;

         always_comb
         begin
            if (prog_to_battery[i])
               next_threshold = lpm_sense_pkg::THR_BATTERY; // R8
            else if (lowpower_threshold_programmable[i])
               next_threshold = lpm_sense_pkg::THR_NORMAL; // R7
            else
               next_threshold = lpm_sense_pkg::THR_DELTA; // R6
         end

         always_ff @(posedge mclk)
         begin
            if (sys_rst)
            begin
               prog_comp_enable[i] <= 1'b0;
               prog_poll_current[i] <= 1'b0;
               prog_threshold[2*i+1:2*i] <= lpm_sense_pkg::THR_DELTA;
            end
            else
            begin
               prog_comp_enable[i] <= !low_power_mode || comparator_only_programmable[i]; // R1
               prog_poll_current[i] <= low_power_mode && !comparator_only_programmable[i]; // R1
               prog_threshold[2*i+1:2*i] <= next_threshold; // R6 R7 R8
            end
         end
      end

      for (i = 0; i < GND_N; i++)
      begin : g_gnd
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
            begin
               gnd_comp_enable[i] <= 1'b0;
               gnd_poll_current[i] <= 1'b0;
            end
            else
            begin
               gnd_comp_enable[i] <= !low_power_mode || comparator_only_ground[i]; // R1
               gnd_poll_current[i] <= low_power_mode && !comparator_only_ground[i]; // R1
            end
         end
      end
   endgenerate
endmodule : lpm_input_sense_config

// ==== hdl/lpm_sense_pkg.sv ====
// Constants for the low power input sense configuration block
package lpm_sense_pkg;
   // Frame layout
   localparam int FRAME_BITS = 32;
   localparam int ADDR_MSB = 31;
   localparam int ADDR_LSB = 25;
   localparam int RW_BIT = 24;
   localparam int DATA_BITS = 24;
   localparam int FAULT_BIT = 23;
   localparam int FLAG_BIT = 22;
   localparam int REGDATA_BITS = 22;
   // Register addresses
   localparam logic [6:0] ADDR_COMP_ONLY_PROG = 7'h12;
   localparam logic [6:0] ADDR_COMP_ONLY_GND = 7'h13;
   localparam logic [6:0] ADDR_THRESH_PROG = 7'h14;
   // Channel counts
   localparam int PROG_CHANNELS = 8;
   localparam int GND_CHANNELS = 14;
   // Reset values
   localparam logic [7:0] RESET_COMP_ONLY_PROG = 8'h00;
   localparam logic [13:0] RESET_COMP_ONLY_GND = 14'h0000;
   localparam logic [7:0] RESET_THRESH_PROG = 8'h00;
   // Threshold selection codes
   typedef enum logic [1:0]
   {
      THR_DELTA = 2'h0,
      THR_NORMAL = 2'h1,
      THR_BATTERY = 2'h2
   } threshold_type;
endpackage : lpm_sense_pkg

// ==== verif/lpm_host_model.sv ====
// Host frame master model
`timescale 1ns/10ps
module lpm_host_model (
   // Reply side
   input wire logic mclk,
   input wire logic [23:0] reply_data,
   // Frame side
   output logic frame_valid,
   output logic [31:0] frame_in
);
   initial {frame_valid, frame_in} = 33'h0;
   task automatic xfer(input logic [6:0] a, input logic w, input logic [23:0] d,
      output logic [23:0] q);
      @(posedge mclk) #1 {frame_valid, frame_in} = {1'b1, a, w, d};
      @(posedge mclk) #1 q = reply_data;
      {frame_valid, frame_in} = {1'b0, ~a, w, ~d};
   endtask : xfer
endmodule : lpm_host_model

// ==== verif/lpm_input_sense_config_properties.sv ====
// Port assertions
`timescale 1ns/10ps
module lpm_input_sense_config_properties #(parameter int PROG_N = 8, parameter int GND_N = 14)
(
   // Inputs
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic frame_valid,
   input wire logic fault_status,
   input wire logic interrupt_flag,
   input wire logic low_power_mode,
   input wire logic lp_tick,
   input wire logic [31:0] frame_in,
   input wire logic [PROG_N-1:0] prog_to_battery,
   // Outputs
   input wire logic [23:0] reply_data,
   input wire logic [PROG_N-1:0] prog_comp_enable,
   input wire logic [PROG_N-1:0] prog_poll_current,
   input wire logic [GND_N-1:0] gnd_comp_enable,
   input wire logic [GND_N-1:0] gnd_poll_current,
   input wire logic [2*PROG_N-1:0] prog_threshold,
   input wire logic wake_request
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence unmapped_s;
      frame_valid && (frame_in[31:25] < 7'h12 || frame_in[31:25] > 7'h14);
   endsequence
   AST_STATUS: assert property (frame_valid |=>
      reply_data[23:22] == $past({fault_status, interrupt_flag})) else $error("status");
   AST_UNMAPPED: assert property (unmapped_s |=> reply_data[21:0] == 22'h0) else $error("map");
   AST_RESET: assert property ($past(sys_rst) |-> reply_data == 24'h0) else $error("reset");
   AST_EXCL: assert property (!$past(sys_rst) |-> &(prog_comp_enable ^ prog_poll_current)
      && &(gnd_comp_enable ^ gnd_poll_current)) else $error("excl");
   AST_AWAKE: assert property (!$past(sys_rst) && !$past(low_power_mode) |->
      !prog_poll_current && !gnd_poll_current) else $error("poll");
   AST_BATTERY: assert property (!$past(sys_rst) && $past(prog_to_battery[2]) |->
      prog_threshold[5:4] == 2'h2) else $error("battery");
   AST_WAKE_ONE: assert property (wake_request |=> !wake_request) else $error("width");
   AST_WAKE_LPM: assert property (wake_request |-> $past(low_power_mode)) else $error("wake");
   AST_WAKE_TICK: assert property (wake_request |-> $past(lp_tick)) else $error("tick");
   AST_REPLY_HOLD: assert property (!frame_valid |=> $stable(reply_data)) else $error("hold");
endmodule : lpm_input_sense_config_properties
bind lpm_input_sense_config lpm_input_sense_config_properties
   #(.PROG_N(PROG_N), .GND_N(GND_N)) chk_u (.*);

// ==== verif/lpm_input_sense_config_tb.sv ====
// Bench for the sense configuration block
`timescale 1ns/10ps
module lpm_input_sense_config_tb;
   logic mclk = 1'b0, sys_rst = 1'b1, frame_valid, wake_request, seen;
   logic low_power_mode = 1'b0, lp_tick = 1'b0, fault_status = 1'b1, interrupt_flag = 1'b0;
   logic [31:0] frame_in;
   logic [23:0] reply_data, q, fill [4] = '{24'h8000FF, 24'h803FFF, 24'h8000FF, 24'h800000};
   logic [7:0] prog_to_battery = 8'h00, prog_comp_pin = 8'h00, prog_comp_enable, prog_poll_current;
   logic [13:0] gnd_comp_pin = 14'h0000, gnd_comp_enable, gnd_poll_current;
   logic [15:0] prog_threshold;
   int bad_count = 0, n_checks = 0, cyc = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 3000) finish_test(1);
   lpm_input_sense_config dut_u (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .frame_valid(frame_valid),
      .frame_in(frame_in),
      .fault_status(fault_status),
      .interrupt_flag(interrupt_flag),
      .reply_data(reply_data),
      .low_power_mode(low_power_mode),
      .lp_tick(lp_tick),
      .prog_to_battery(prog_to_battery),
      .prog_comp_pin(prog_comp_pin),
      .gnd_comp_pin(gnd_comp_pin),
      .prog_comp_enable(prog_comp_enable),
      .prog_poll_current(prog_poll_current),
      .gnd_comp_enable(gnd_comp_enable),
      .gnd_poll_current(gnd_poll_current),
      .prog_threshold(prog_threshold),
      .wake_request(wake_request)
   );
   lpm_host_model host_u (
      .mclk(mclk),
      .reply_data(reply_data),
      .frame_valid(frame_valid),
      .frame_in(frame_in)
   );
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      n_checks++;
      bad_count += int'(g !== e);
      if (g !== e) $display("BAD %s expected %h seen %h", n, e, g);
   endtask : chk
   task automatic tick;
      repeat (3) @(posedge mclk);
      #1 {lp_tick, seen} = 2'b10;
      repeat (4) @(posedge mclk) #1 {lp_tick, seen} = {1'b0, seen | wake_request};
   endtask : tick
   task automatic test_registers;
      for (int i = 0; i < 4; i++)
      begin
         host_u.xfer(7'(32'h12 + i), 1'b1, 24'hFFFFFF, q);
         chk("reset", 24'h800000, q);
         host_u.xfer(7'(32'h12 + i), 1'b0, 24'h000000, q);
         chk("readback", fill[i], q);
      end
      $display("registers done");
   endtask : test_registers
   task automatic test_threshold;
      prog_to_battery = 8'h04;
      interrupt_flag = 1'b1;
      host_u.xfer(7'h14, 1'b1, 24'h000001, q);
      chk("flag", 24'hC000FF, q);
      @(posedge mclk) #1;
      chk("threshold", 24'h000021, {8'h00, prog_threshold});
      $display("threshold done");
   endtask : test_threshold
   task automatic test_wake;
      host_u.xfer(7'h13, 1'b1, 24'h000F0F, q);
      chk("gnd old", 24'hC03FFF, q);
      host_u.xfer(7'h12, 1'b1, 24'h000001, q);
      chk("prog old", 24'hC000FF, q);
      low_power_mode = 1'b1;
      @(posedge mclk) #1;
      chk("lp outputs", 24'h00FE01, {8'h00, prog_poll_current, prog_comp_enable});
      chk("gnd enable", 24'h000F0F, {10'h0, gnd_comp_enable});
      chk("gnd poll", 24'h0030F0, {10'h0, gnd_poll_current});
      prog_comp_pin = 8'h02;
      tick();
      chk("no wake", 24'h000000, {23'h0, seen});
      prog_comp_pin = 8'h03;
      tick();
      chk("wake", 24'h000001, {23'h0, seen});
      gnd_comp_pin = 14'h0010;
      tick();
      chk("gnd no wake", 24'h000000, {23'h0, seen});
      gnd_comp_pin = 14'h0011;
      tick();
      chk("gnd wake", 24'h000001, {23'h0, seen});
      $display("wake done");
   endtask : test_wake
   task automatic test_reset;
      sys_rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 sys_rst = 1'b0;
      host_u.xfer(7'h13, 1'b0, 24'h000000, q);
      chk("gnd after reset", 24'hC00000, q);
      chk("poll after reset", 24'h0000FF, {16'h0000, prog_poll_current});
      $display("reset done");
   endtask : test_reset
   initial
   begin
      repeat (10) @(posedge mclk);
      #1 sys_rst = 1'b0;
      test_registers();
      test_threshold();
      test_wake();
      test_reset();
      finish_test(0);
   end
   task automatic finish_test(input int lost);
      bad_count += lost;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
endmodule : lpm_input_sense_config_tb
